// *** logic/gpps_pkg.sv ***
// Package for the general-purpose I/O port block with pin-shared function selection.
// Assumes an 8-bit data-memory style register port with one-cycle read and write strobes.
package gpps_pkg;

  // Port counts and widths
  localparam int NUM_PORTS  = 8;
  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 6;

  // Register index bases: per port five registers (data, direction, pull-high, select lo, select hi)
  localparam logic [5:0] OFS_DATA_BASE = 6'h00;  // port n data at 0x00 + n
  localparam logic [5:0] OFS_DIR_BASE  = 6'h08;  // port n direction at 0x08 + n
  localparam logic [5:0] OFS_PU_BASE   = 6'h10;  // port n pull-high at 0x10 + n
  localparam logic [5:0] OFS_WAKE      = 6'h18;  // first port wake enables
  localparam logic [5:0] OFS_FSEL_BASE = 6'h20;  // port n select lo at 0x20+2n, hi at 0x21+2n
  localparam logic [5:0] OFS_IROUTE    = 6'h30;  // input route select

  // Reset values
  localparam logic [7:0] RST_DATA  = 8'hFF;
  localparam logic [7:0] RST_DIR   = 8'hFF;  // All pins input after reset
  localparam logic [7:0] RST_PU    = 8'h00;
  localparam logic [7:0] RST_WAKE  = 8'h00;
  localparam logic [7:0] RST_FSEL  = 8'h00;  // Every field selects plain I/O
  localparam logic [7:0] RST_ROUTE = 8'h00;

  // Implemented bit masks, field codes and idle read value
  localparam logic [7:0] IROUTE_MASK  = 8'h3F;  // Bits 5..0 only
  localparam logic [7:0] PORTD_HI_MSK = 8'h3F;  // Upper selection register of port D
  localparam logic [1:0] FSEL_GPIO    = 2'h0;
  localparam logic [1:0] DIR_OUTPUT   = 2'h0;
  localparam logic [7:0] RDATA_IDLE   = 8'h00;

endpackage : gpps_pkg

// *** logic/gpps_port_ctrl.sv ***
// Top of the I/O port block: data latches, direction, pull-high, first-port wake-up,
// output-function selection per pin and the input route select register.
// Assumes a single-cycle 8-bit register port and asynchronous pin inputs.
// Operation
// - Direction bit: 0 output, 1 input
// - Input pin read returns pin level
// - Output pin read returns latch contents
// - Pull-high enable bit per pin
// - Pull-high only for input or open-drain
// - Per-pin wake enable on first port
// - Falling edge on enabled pin wakes
// - Wake only for GPIO in power-down
// - Unimplemented bits read as zero
// - Output-function and input-route selection registers
// - Input route uses bits five to zero
// - Latch holds value; inputs sampled live
// - Two-bit fields per pin, reset GPIO
module gpps_port_ctrl #(
  parameter int NPORT = gpps_pkg::NUM_PORTS,
  parameter int PW    = gpps_pkg::PORT_WIDTH
) (
  // Clock and reset
  input  wire logic                                    CLOCK_I,
  input  wire logic                                    RESET_N_I,
  // Register port
  input  wire logic [gpps_pkg::ADDR_WIDTH-1:0]         REG_ADDR_I,
  input  wire logic                                    REG_WR_I,
  input  wire logic                                    REG_RD_I,
  input  wire logic [7:0]                              REG_WDATA_I,
  output logic      [7:0]                              REG_RDATA_O,
  // Pins
  input  wire logic [NPORT*PW-1:0]                     PIN_IN_I,
  output logic      [NPORT*PW-1:0]                     PIN_OUT_O,
  output logic      [NPORT*PW-1:0]                     PIN_OE_O,
  output logic      [NPORT*PW-1:0]                     PIN_PULLUP_O,
  // Function selection to peripherals, open-drain mode from them
  input  wire logic [NPORT*PW-1:0]                     PIN_OPEN_DRAIN_I,
  output logic      [2*NPORT*PW-1:0]                   FUNC_SEL_O,
  output logic      [5:0]                              INPUT_ROUTE_O,
  // Power management
  input  wire logic                                    POWER_DOWN_I,
  output logic                                         WAKE_REQ_O
);

  localparam int NP = NPORT * PW;

  // Register storage, indexed by port
  logic [PW-1:0] latch_q [NPORT];
  logic [PW-1:0] dir_q   [NPORT];
  logic [PW-1:0] pu_q    [NPORT];
  logic [7:0]    fsel_q  [2*NPORT];
  logic [PW-1:0] wake_q;
  logic [7:0]    route_q;

  // Pin synchroniser stages and previous level for edge detection
  logic [NP-1:0] sync1_q;
  logic [NP-1:0] sync2_q;
  logic [PW-1:0] wake_prev_q;
  logic [PW-1:0] wake_hit;

  // Decoded register hits
  logic [NPORT-1:0]   hit_data;
  logic [NPORT-1:0]   hit_dir;
  logic [NPORT-1:0]   hit_pu;
  logic [2*NPORT-1:0] hit_fsel;
  wire                hit_wake  = (REG_ADDR_I == gpps_pkg::OFS_WAKE);
  wire                hit_route = (REG_ADDR_I == gpps_pkg::OFS_IROUTE);

  // Per-port read values and pin side
  logic [7:0] rd_data [NPORT];
  logic [7:0] rd_dir  [NPORT];
  logic [7:0] rd_pu   [NPORT];
  logic [7:0] rd_fsel [2*NPORT];
  logic [NP-1:0] out_d;
  logic [NP-1:0] oe_d;
  logic [NP-1:0] pu_d;
  logic [NP-1:0] gpio_sel;

  genvar gp;
  genvar gb;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      assign hit_data[gp] = (REG_ADDR_I == gpps_pkg::OFS_DATA_BASE + 6'(gp));
      assign hit_dir[gp]  = (REG_ADDR_I == gpps_pkg::OFS_DIR_BASE + 6'(gp));
      assign hit_pu[gp]   = (REG_ADDR_I == gpps_pkg::OFS_PU_BASE + 6'(gp));
      assign hit_fsel[2*gp]   = (REG_ADDR_I == gpps_pkg::OFS_FSEL_BASE + 6'(2*gp));
      assign hit_fsel[2*gp+1] = (REG_ADDR_I == gpps_pkg::OFS_FSEL_BASE + 6'(2*gp+1));
      assign rd_dir[gp]  = 8'(dir_q[gp]);
      assign rd_pu[gp]   = 8'(pu_q[gp]);
      assign rd_fsel[2*gp]   = fsel_q[2*gp];
      assign rd_fsel[2*gp+1] = fsel_q[2*gp+1];

      // Per-pin data path
      for (gb = 0; gb < PW; gb++) begin : g_bit
        localparam int N = gp*PW + gb;
        wire [1:0] fld = (gb < 4) ? fsel_q[2*gp][2*(gb%4) +: 2] : fsel_q[2*gp+1][2*(gb%4) +: 2];
        wire is_in = dir_q[gp][gb];
        assign gpio_sel[N] = (fld == gpps_pkg::FSEL_GPIO);
        // Input shows the synchronised pin, output shows the latch
        assign rd_data[gp][gb] = is_in ? sync2_q[N] : latch_q[gp][gb];
        assign out_d[N] = latch_q[gp][gb];
        // Open drain only pulls low; otherwise push-pull under the direction bit
        assign oe_d[N]  = !is_in && (!PIN_OPEN_DRAIN_I[N] || !latch_q[gp][gb]);
        // Pull-high only on an input or an open-drain output
        assign pu_d[N]  = pu_q[gp][gb] && (is_in || PIN_OPEN_DRAIN_I[N]);
        assign FUNC_SEL_O[2*N +: 2] = fld;
      end
    end
  endgenerate

  // Falling edges on first-port pins, qualified by GPIO selection and power-down
  assign wake_hit = wake_prev_q & ~sync2_q[PW-1:0] & wake_q & gpio_sel[PW-1:0]
                    & {PW{POWER_DOWN_I}};

  // Read mux; unmapped addresses and missing bits return zero
  logic [7:0] rdata_d;
  always_comb begin
    rdata_d = gpps_pkg::RDATA_IDLE;
    for (int i = 0; i < NPORT; i++) begin
      if (hit_data[i]) begin
        rdata_d = rd_data[i];
      end
      if (hit_dir[i]) begin
        rdata_d = rd_dir[i];
      end
      if (hit_pu[i]) begin
        rdata_d = rd_pu[i];
      end
    end
    for (int j = 0; j < 2*NPORT; j++) begin
      if (hit_fsel[j]) begin
        rdata_d = rd_fsel[j];
      end
    end
    if (hit_wake) begin
      rdata_d = 8'(wake_q);
    end
    if (hit_route) begin
      rdata_d = route_q;
    end
  end

  // Two-stage synchroniser; only the second stage feeds reads and edge detection
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sync1_q     <= '0;
      sync2_q     <= '0;
      wake_prev_q <= '0;
    end else begin
      sync1_q     <= PIN_IN_I;
      sync2_q     <= sync1_q;
      wake_prev_q <= sync2_q[PW-1:0];
    end
  end

  // Port registers; latches change only on a write
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (int i = 0; i < NPORT; i++) begin
        latch_q[i] <= PW'(gpps_pkg::RST_DATA);
        dir_q[i]   <= PW'(gpps_pkg::RST_DIR);
        pu_q[i]    <= PW'(gpps_pkg::RST_PU);
      end
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        if (REG_WR_I && hit_data[i]) begin
          latch_q[i] <= REG_WDATA_I[PW-1:0];
        end
        if (REG_WR_I && hit_dir[i]) begin
          dir_q[i] <= REG_WDATA_I[PW-1:0];
        end
        if (REG_WR_I && hit_pu[i]) begin
          pu_q[i] <= REG_WDATA_I[PW-1:0];
        end
      end
    end
  end

  // Selection, wake and route registers
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (int j = 0; j < 2*NPORT; j++) begin
        fsel_q[j] <= gpps_pkg::RST_FSEL;
      end
      wake_q  <= PW'(gpps_pkg::RST_WAKE);
      route_q <= gpps_pkg::RST_ROUTE;
    end else begin
      for (int j = 0; j < 2*NPORT; j++) begin
        if (REG_WR_I && hit_fsel[j]) begin
          // Port D upper selector has only three fields
          fsel_q[j] <= (j == 7) ? (REG_WDATA_I & gpps_pkg::PORTD_HI_MSK) : REG_WDATA_I;
        end
      end
      if (REG_WR_I && hit_wake) begin
        wake_q <= REG_WDATA_I[PW-1:0];
      end
      if (REG_WR_I && hit_route) begin
        route_q <= REG_WDATA_I & gpps_pkg::IROUTE_MASK;
      end
    end
  end

  // Registered outputs; read data is held from the cycle after the strobe
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O   <= gpps_pkg::RDATA_IDLE;
      PIN_OUT_O     <= '0;
      PIN_OE_O      <= '0;
      PIN_PULLUP_O  <= '0;
      INPUT_ROUTE_O <= '0;
      WAKE_REQ_O    <= 1'b0;
    end else begin
      if (REG_RD_I) begin
        REG_RDATA_O <= rdata_d;
      end
      PIN_OUT_O     <= out_d;
      PIN_OE_O      <= oe_d;
      PIN_PULLUP_O  <= pu_d;
      INPUT_ROUTE_O <= route_q[5:0];
      WAKE_REQ_O    <= |wake_hit;
    end
  end

endmodule : gpps_port_ctrl

// *** tb/gpps_pin_model.sv ***
// Pad model for the port block: resolves each pad from block drive, pull-high and an outside driver.
// The bench leaves the outside driver enabled even on pads the block drives as outputs; block drive wins there.
module gpps_pin_model (
  // Block side
  input  wire logic [63:0] oe_i,
  input  wire logic [63:0] out_i,
  input  wire logic [63:0] pu_i,
  // Outside driver
  input  wire logic [63:0] ext_i,
  input  wire logic [63:0] ext_en_i,
  // Pad levels
  output logic      [63:0] level_o
);
  // Block drive wins, then an enabled outside driver; a pad driven by neither is high when pulled up, else takes the outside level
  assign level_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i) | (~oe_i & ~ext_en_i & (pu_i | ext_i));
endmodule : gpps_pin_model

// *** tb/gpps_port_ctrl_asserts.sv ***
// Checker for the port block: register effects, pull-high gating and wake qualification.
// Sees only the top ports and is bound to every instance of the top.
module gpps_port_ctrl_asserts #(
  parameter int NPORT = 8,
  parameter int PW    = 8
) (
  // Clock, reset and register port
  input wire logic                    CLOCK_I,
  input wire logic                    RESET_N_I,
  input wire logic [5:0]              REG_ADDR_I,
  input wire logic                    REG_WR_I,
  input wire logic                    REG_RD_I,
  input wire logic [7:0]              REG_WDATA_I,
  input wire logic [7:0]              REG_RDATA_O,
  // Pins, selection and power
  input wire logic [NPORT*PW-1:0]     PIN_OUT_O,
  input wire logic [NPORT*PW-1:0]     PIN_OE_O,
  input wire logic [NPORT*PW-1:0]     PIN_PULLUP_O,
  input wire logic [NPORT*PW-1:0]     PIN_OPEN_DRAIN_I,
  input wire logic [2*NPORT*PW-1:0]   FUNC_SEL_O,
  input wire logic [5:0]              INPUT_ROUTE_O,
  input wire logic                    POWER_DOWN_I,
  input wire logic                    WAKE_REQ_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);
  a_route_write: assert property (
    REG_WR_I && REG_ADDR_I == 6'h30 |=> ##1 {2'h0, INPUT_ROUTE_O} == ($past(REG_WDATA_I, 2) & 8'h3F)) else $error("route mismatch");
  a_route_read: assert property (
    REG_RD_I && REG_ADDR_I == 6'h30 |=> REG_RDATA_O == {2'h0, $past(INPUT_ROUTE_O)}) else $error("route readback wrong");
  a_unmapped_zero: assert property (
    REG_RD_I && REG_ADDR_I == 6'h3F |=> REG_RDATA_O == 8'h00) else $error("unmapped read not zero");
  a_fsel_write: assert property (
    REG_WR_I && REG_ADDR_I == 6'h20 |=> FUNC_SEL_O[7:0] == $past(REG_WDATA_I)) else $error("select field wrong");
  a_dir_drive: assert property (
    REG_WR_I && REG_ADDR_I == 6'h09 ##1 !REG_WR_I && PIN_OPEN_DRAIN_I[15:8] == 8'h00
    |=> PIN_OE_O[15:8] == ~$past(REG_WDATA_I, 2)) else $error("drive enable not per direction");
  a_latch_out: assert property (
    REG_WR_I && REG_ADDR_I == 6'h01 ##1 !REG_WR_I |=> PIN_OUT_O[15:8] == $past(REG_WDATA_I, 2)) else $error("latch wrong");
  // Push-pull drive with the pull-high on would fight the output stage
  a_pullup_gate: assert property (
    (PIN_PULLUP_O & PIN_OE_O & ~$past(PIN_OPEN_DRAIN_I)) == '0) else $error("pull-high on a push-pull output");
  a_wake_pd: assert property (
    WAKE_REQ_O |-> $past(POWER_DOWN_I)) else $error("wake outside power-down");
endmodule : gpps_port_ctrl_asserts

bind gpps_port_ctrl gpps_port_ctrl_asserts #(.NPORT(NPORT), .PW(PW)) u_gpps_port_ctrl_asserts (.*);

// *** tb/gpps_port_ctrl_test.sv ***
// Self-checking bench for the port block: registers, pin readback, pull-high and wake-up.
// Assumes the pad model resolves pins; inputs change at the falling clock edge.
module gpps_port_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
  logic         clk, rst_n, wr, rd, pd, wake;
  logic [5:0]   addr, route;
  logic [7:0]   wdata, rdata, r, d, w, e;
  logic [63:0]  pin_in, pout, oe, pu, od, ext, ext_en;
  logic [127:0] fsel;
  int           bad_count, compares, seed, k, hits;
  gpps_port_ctrl u_gpps_port_ctrl (.CLOCK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .PIN_IN_I(pin_in), .PIN_OUT_O(pout),
    .PIN_OE_O(oe), .PIN_PULLUP_O(pu), .PIN_OPEN_DRAIN_I(od), .FUNC_SEL_O(fsel), .INPUT_ROUTE_O(route),
    .POWER_DOWN_I(pd), .WAKE_REQ_O(wake));
  gpps_pin_model u_gpps_pin_model (.oe_i(oe), .out_i(pout), .pu_i(pu), .ext_i(ext), .ext_en_i(ext_en),
    .level_o(pin_in));
  // Inputs read the pad, outputs read the latch
  function automatic logic [7:0] exp_rd(input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] pad);
    return (lat & ~dir) | (pad & dir);
  endfunction : exp_rd
  // Strobes rise and fall at falling edges so each is held across exactly one rising edge
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  task automatic chk_rd(input logic [5:0] a, input logic [7:0] x);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    `CHK(rdata, x)
  endtask : chk_rd
  task automatic print_verdict();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard far above the roughly 4 us the test needs
  initial begin
    #1ms;
    bad_count++;
    print_verdict();
  end
  initial begin
    seed = 32'h26B9;
    {rst_n, wr, rd, pd, addr, wdata, od} = '0;
    ext = '1;
    ext_en = '1;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk_rd(6'h08, 8'hFF);
    chk_rd(6'h10, 8'h00);
    chk_rd(6'h18, 8'h00);
    chk_rd(6'h20, 8'h00);
    chk_rd(6'h3F, 8'h00);
    for (k = 0; k < 8; k++) begin
      w = 8'($random(seed));
      wr_reg(6'h10 + 6'(k), w);
      chk_rd(6'h10 + 6'(k), w);
    end
    wr_reg(6'h30, 8'hFF);
    chk_rd(6'h30, 8'h3F);
    wr_reg(6'h27, 8'hFF);
    chk_rd(6'h27, 8'h3F);
    $display("register test done");
    for (k = 0; k < 8; k++) begin
      d = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
      w = 8'($random(seed));
      e = 8'($random(seed));
      wr_reg(6'h09, d);
      wr_reg(6'h01, w);
      ext[15:8] = e;
      repeat (4) @(negedge clk);
      chk_rd(6'h01, exp_rd(d, w, e));
      `CHK(pout[15:8], w)
      `CHK(oe[15:8], ~d)
    end
    $display("readback test done");
    wr_reg(6'h12, 8'hFF);
    wr_reg(6'h0A, 8'hF0);
    od[17] = 1'b1;
    ext_en[23:16] = 8'h00;
    repeat (4) @(negedge clk);
    `CHK(pu[23:16], 8'hF2)
    chk_rd(6'h02, 8'hFF);
    od[17] = 1'b0;
    wr_reg(6'h22, 8'h01);
    wr_reg(6'h30, 8'h01);
    `CHK(fsel[17:16], 2'h1)
    $display("pull-high test done");
    // Pin stays a plain I/O while the route picks the interrupt source
    wr_reg(6'h30, 8'h02);
    chk_rd(6'h30, 8'h02);
    `CHK(route, 6'h02)
    wr_reg(6'h18, 8'h01);
    // Pass 0 qualifies; pass 1 leaves power-down; pass 2 gives the pin a shared function
    for (k = 0; k < 3; k++) begin
      pd = (k != 1);
      if (k == 2) wr_reg(6'h20, 8'h01);
      ext[0] = 1'b1;
      repeat (5) @(negedge clk);
      ext[0] = 1'b0;
      hits = 0;
      repeat (8) begin
        @(negedge clk);
        hits += int'(wake === 1'b1);
      end
      `CHK(hits, (k == 0) ? 1 : 0)
    end
    $display("wake test done");
    print_verdict();
  end
endmodule : gpps_port_ctrl_test
